// ---- shared/asc_map.vh ----
// register map, field positions, reset values and rate figures
`ifndef ASC_MAP_VH
`define ASC_MAP_VH

// ============================================================
// register byte offsets
`define ASC_OFF_CTRL     8'h00
`define ASC_OFF_RLEN     8'h04
`define ASC_OFF_SCALE    8'h08
`define ASC_OFF_STATUS   8'h0C
`define ASC_OFF_RDADDR   8'h10
`define ASC_OFF_RDDATA   8'h14

// ============================================================
// control fields
`define ASC_CTRL_START   0
`define ASC_CTRL_ET      1
`define ASC_CTRL_SINC    2
`define ASC_CTRL_SPATH   3
`define ASC_CTRL_CHON    4
`define ASC_CTRL_RECCH   8
`define ASC_CTRL_PMAX    10
`define ASC_CTRL_DEC     12
`define ASC_CTRL_FILL    16
`define ASC_CTRL_MASK    32'h0007_77FE

// ============================================================
// status fields
`define ASC_ST_BUSY      0
`define ASC_ST_DONE      1
`define ASC_ST_MODE      2
`define ASC_ST_NCH       4
`define ASC_ST_PMASK     16

// ============================================================
// reset values
`define ASC_CTRL_RST     32'h0000_00F0
`define ASC_RLEN_RST     32'h0000_01F4
`define ASC_SCALE_RST    24'h00_03E8
`define ASC_ROUTE_RST    8'hE4

// ============================================================
// rates and thresholds
`define ASC_RATE_1CH_MSPS  4000
`define ASC_RATE_2CH_MSPS  1000
`define ASC_RATE_34CH_MSPS 500
`define ASC_SP_THRESH_NS   10

`endif

// ---- logic/asc_rec_mem.v ----
// record memory, one write port and one registered read port
`timescale 1ns/1ps
module asc_rec_mem #(
  parameter DW = 9,
  parameter AW = 14
) (
  // clock
  input  wire          clk,
  // write port
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  // read port
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end

endmodule // asc_rec_mem

// ---- logic/asc_interp.v ----
// point interpolator: straight line or three point curve fit
`timescale 1ns/1ps
module asc_interp #(
  parameter SW = 8
) (
  // clock
  input  wire          clk,
  // neighbouring real samples
  input  wire [SW-1:0] s0,
  input  wire [SW-1:0] s1,
  input  wire [SW-1:0] s2,
  // position between s0 and s1, eight fraction bits
  input  wire [7:0]    frac,
  input  wire          sinc,
  // result, one cycle later
  output reg  [SW-1:0] y
);

  reg signed [31:0] e0;
  reg signed [31:0] e1;
  reg signed [31:0] e2;
  reg signed [31:0] tt;
  reg signed [31:0] acc;

  always @*
  begin
    e0 = {{(32-SW){1'b0}}, s0};
    e1 = {{(32-SW){1'b0}}, s1};
    e2 = {{(32-SW){1'b0}}, s2};
    tt = {24'h00_0000, frac};
    acc = e0 + (((e1 - e0) * tt) >>> 8);
    if (sinc)
      acc = acc + (((e2 - e1 - e1 + e0) * tt
            * (tt - 32'sh0000_0100)) >>> 17);
    if (acc < 0)
      acc = 32'sh0000_0000;
    else if (acc > $signed((32'h0000_0001 << SW) - 1))
      acc = $signed((32'h0000_0001 << SW) - 1);
  end

  always @(posedge clk)
  begin
    y <= acc[SW-1:0];
  end

endmodule // asc_interp

// ---- logic/asc_acq_top.v ----
// acquisition sampling control with ahb-lite register slave
//
// Behaviour
// - sample at fixed interval, digitize, store with position from trigger
// - record holds exactly the configured length of points after trigger
// - several samples per point may be averaged or peak-picked
// - real-time mode fills whole record from one trigger
// - equivalent-time only when enabled and rate too high for real time
// - equivalent-time gathers samples over repeated triggers until full
// - equivalent-time samples placed by measured offset from trigger
// - single-path variant interpolates when scale faster than 10 ns
// - linear interpolation puts points on line between real samples
// - sin(x)/x interpolation fits a curve through real samples
// - digitizers of off channels are lent to on channels
// - max per-channel rate depends on number of channels on
// - too-fast scale leads to interpolation or equivalent-time
// - fill points with currently selected interpolation method
// - equivalent-time off means real time plus interpolation
`timescale 1ns/1ps
`include "asc_map.vh"
module asc_acq_top #(
  parameter SW    = 8,
  parameter AW    = 14,
  parameter FLMAX = 4
) (
  // clock and reset
  input  wire              hclk,
  input  wire              hresetn,
  // ahb-lite slave
  input  wire              hsel,
  input  wire [31:0]       haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire              hready,
  input  wire [31:0]       hwdata,
  output reg               hreadyout,
  output reg               hresp,
  output reg  [31:0]       hrdata,
  // front end
  input  wire [4*SW-1:0]   adc_d,
  input  wire              trig_pin,
  input  wire [FLMAX-1:0]  et_phase_pin,
  output reg  [7:0]        dig_route,
  // record point stream
  output reg               pt_valid,
  output reg  [AW-1:0]     pt_index,
  output reg  [SW-1:0]     pt_data,
  output reg               pt_real
);

  localparam MW = 1 << FLMAX;
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_ARM  = 2'd1;
  localparam [1:0] S_CAP  = 2'd2;
  localparam [1:0] M_RT   = 2'd0;
  localparam [1:0] M_ET   = 2'd1;
  localparam [1:0] M_IP   = 2'd2;
  localparam [2:0] R_CTRL = 3'd0;
  localparam [2:0] R_RLEN = 3'd1;
  localparam [2:0] R_SCAL = 3'd2;
  localparam [2:0] R_STAT = 3'd3;
  localparam [2:0] R_RDA  = 3'd4;
  localparam [2:0] R_RDD  = 3'd5;
  localparam [2:0] R_NONE = 3'd7;
  localparam [23:0] IV1_PS  = 1000000 / `ASC_RATE_1CH_MSPS;
  localparam [23:0] IV2_PS  = 1000000 / `ASC_RATE_2CH_MSPS;
  localparam [23:0] IV34_PS = 1000000 / `ASC_RATE_34CH_MSPS;
  localparam [23:0] SP_PS   = `ASC_SP_THRESH_NS * 1000;
  localparam [31:0] RLEN_RST = `ASC_RLEN_RST;

  // ============================================================
  // functions
  function [2:0] asc_dec;
    input [7:0] a;
    begin
      if (a == `ASC_OFF_CTRL)
        asc_dec = R_CTRL;
      else if (a == `ASC_OFF_RLEN)
        asc_dec = R_RLEN;
      else if (a == `ASC_OFF_SCALE)
        asc_dec = R_SCAL;
      else if (a == `ASC_OFF_STATUS)
        asc_dec = R_STAT;
      else if (a == `ASC_OFF_RDADDR)
        asc_dec = R_RDA;
      else if (a == `ASC_OFF_RDDATA)
        asc_dec = R_RDD;
      else
        asc_dec = R_NONE;
    end
  endfunction

  function [1:0] asc_owner;
    input [3:0] on;
    input [1:0] d;
    begin
      if (on[d])
        asc_owner = d;
      else if (on[d ^ 2'd1])
        asc_owner = d ^ 2'd1;
      else if (on[d ^ 2'd2])
        asc_owner = d ^ 2'd2;
      else
        asc_owner = d ^ 2'd3;
    end
  endfunction

  function [1:0] asc_next_lane;
    input [7:0] rt;
    input [1:0] ch;
    input [1:0] cur;
    reg   [1:0] k;
    integer     i;
    begin
      asc_next_lane = cur;
      for (i = 3; i >= 1; i = i - 1)
      begin
        k = cur + i[1:0];
        if (rt[2*k +: 2] == ch)
          asc_next_lane = k;
      end
    end
  endfunction

  // ============================================================
  // registers
  reg  [31:0]      ctrl_r;
  reg  [AW:0]      rlen_r;
  reg  [23:0]      scale_r;
  reg  [AW-1:0]    rdaddr_r;
  reg              done_r;
  reg  [1:0]       state_r;
  reg  [1:0]       mode_r;
  reg  [2:0]       fl_r;
  reg  [1:0]       lane_r;
  reg  [AW:0]      pidx_r;
  reg  [6:0]       sub_r;
  reg  [SW+6:0]    acc_r;
  reg  [FLMAX-1:0] pace_r;
  reg  [1:0]       hcnt_r;
  reg  [SW-1:0]    s0_r;
  reg  [SW-1:0]    s1_r;
  reg  [SW-1:0]    s2_r;
  reg  [FLMAX-1:0] ph_r;
  reg  [MW-1:0]    pmask_r;
  reg              wv_r;
  reg  [AW-1:0]    wa_r;
  reg  [SW-1:0]    wd_r;
  reg              wreal_r;
  reg              wr_pend_r;
  reg  [2:0]       wsel_r;
  reg              trig_s1_r;
  reg              trig_s2_r;
  reg              trig_s3_r;
  reg  [FLMAX-1:0] ph_s1_r;
  reg  [FLMAX-1:0] ph_s2_r;

  // ============================================================
  // control decode
  wire [31:0]   ctrl_nxt = (wr_pend_r && (wsel_r == R_CTRL))
                         ? (hwdata & `ASC_CTRL_MASK) : ctrl_r;
  wire          et_en  = ctrl_nxt[`ASC_CTRL_ET];
  wire          sinc   = ctrl_r[`ASC_CTRL_SINC];
  wire          spath  = ctrl_nxt[`ASC_CTRL_SPATH];
  wire [3:0]    chon   = ctrl_nxt[`ASC_CTRL_CHON +: 4];
  wire [1:0]    recch  = ctrl_r[`ASC_CTRL_RECCH +: 2];
  wire          pmax   = ctrl_r[`ASC_CTRL_PMAX];
  wire [2:0]    dec    = ctrl_r[`ASC_CTRL_DEC +: 3];
  wire [2:0]    fl_raw = ctrl_nxt[`ASC_CTRL_FILL +: 3];
  wire [2:0]    fl_w   = (fl_raw > FLMAX) ? FLMAX[2:0] : fl_raw;
  wire [2:0]    nch    = {2'b00, chon[0]} + {2'b00, chon[1]}
                       + {2'b00, chon[2]} + {2'b00, chon[3]};
  wire [23:0]   min_iv = (nch <= 3'd1) ? IV1_PS :
                         (nch == 3'd2) ? IV2_PS : IV34_PS;
  wire          fast   = spath ? (scale_r < SP_PS)
                               : (scale_r < min_iv);
  wire [1:0]    mode_w = !fast ? M_RT :
                         (et_en && !spath) ? M_ET : M_IP;
  wire [7:0]    route_w;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_route
      localparam [1:0] DG = g;
      assign route_w[2*g +: 2] = asc_owner(chon, DG);
    end
  endgenerate

  // ============================================================
  // sample path
  wire [SW-1:0]    smp    = adc_d[lane_r*SW +: SW];
  wire [SW+6:0]    smp_x  = {7'h00, smp};
  wire [SW+6:0]    sum_w  = ((sub_r == 7'h00) ? {(SW+7){1'b0}} : acc_r)
                          + smp_x;
  wire [SW+6:0]    max_w  = ((sub_r == 7'h00) || (smp_x > acc_r))
                          ? smp_x : acc_r;
  wire [SW+6:0]    avg_w  = sum_w >> dec;
  wire [6:0]       sub_lst = (7'h01 << dec) - 7'h01;
  wire [FLMAX-1:0] pace_lst = ({FLMAX{1'b1}} >> (FLMAX - fl_r));
  wire [FLMAX+7:0] fr_w   = {pace_r, 8'h00} >> fl_r;
  wire [AW:0]      pnext  = pidx_r + {{AW{1'b0}}, 1'b1};
  wire [AW+FLMAX:0] eidx  = ({{FLMAX{1'b0}}, pidx_r} << fl_r)
                          | {{(AW+1){1'b0}}, ph_r};
  wire [MW-1:0]    pm_nxt = pmask_r | ({{(MW-1){1'b0}}, 1'b1} << ph_r);
  wire [MW-1:0]    pm_all = {MW{1'b1}} >> (MW - (1 << fl_r));
  wire             trig_edge = trig_s2_r & ~trig_s3_r;
  wire [SW-1:0]    y_ip;
  wire [SW-1:0]    wdat   = (mode_r == M_IP) ? y_ip : wd_r;
  wire [SW:0]      rd_mem;

  // ============================================================
  // bus decode
  wire ap    = hsel & hready & htrans[1];
  wire wr_go = wr_pend_r;
  wire start_w = wr_go && (wsel_r == R_CTRL)
               && hwdata[`ASC_CTRL_START] && (state_r == S_IDLE);
  reg  [31:0] st_w;
  reg  [31:0] rd_w;

  always @*
  begin
    st_w = 32'h0000_0000;
    st_w[`ASC_ST_BUSY] = (state_r != S_IDLE);
    st_w[`ASC_ST_DONE] = done_r;
    st_w[`ASC_ST_MODE +: 2] = mode_r;
    st_w[`ASC_ST_NCH +: 3] = nch;
    st_w[`ASC_ST_PMASK +: MW] = pmask_r;
    rd_w = 32'h0000_0000;
    case (asc_dec(haddr[7:0]))
      R_CTRL: rd_w = ctrl_r;
      R_RLEN: rd_w[AW:0] = rlen_r;
      R_SCAL: rd_w[23:0] = scale_r;
      R_STAT: rd_w = st_w;
      R_RDA:  rd_w[AW-1:0] = rdaddr_r;
      R_RDD:  rd_w[SW:0] = rd_mem;
      default: rd_w = 32'h0000_0000;
    endcase
  end

  // ============================================================
  // ahb-lite slave and registers
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      wsel_r    <= R_NONE;
      ctrl_r    <= `ASC_CTRL_RST;
      rlen_r    <= RLEN_RST[AW:0];
      scale_r   <= `ASC_SCALE_RST;
      rdaddr_r  <= {AW{1'b0}};
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= ap & hwrite;
      if (ap)
        wsel_r <= asc_dec(haddr[7:0]);
      hrdata <= (ap && !hwrite) ? rd_w : 32'h0000_0000;
      if (wr_go)
      begin
        if (wsel_r == R_CTRL)
          ctrl_r <= hwdata & `ASC_CTRL_MASK;
        else if (wsel_r == R_RLEN)
          rlen_r <= hwdata[AW:0];
        else if (wsel_r == R_SCAL)
          scale_r <= hwdata[23:0];
        else if (wsel_r == R_RDA)
          rdaddr_r <= hwdata[AW-1:0];
      end
    end
  end

  // ============================================================
  // pin synchronisers
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_s3_r <= 1'b0;
      ph_s1_r   <= {FLMAX{1'b0}};
      ph_s2_r   <= {FLMAX{1'b0}};
    end
    else
    begin
      trig_s1_r <= trig_pin;
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
      ph_s1_r   <= et_phase_pin;
      ph_s2_r   <= ph_s1_r;
    end
  end

  // ============================================================
  // acquisition sequencer
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= S_IDLE;
      mode_r  <= M_RT;
      fl_r    <= 3'd0;
      done_r  <= 1'b0;
      dig_route <= `ASC_ROUTE_RST;
      lane_r  <= 2'd0;
      pidx_r  <= {(AW+1){1'b0}};
      sub_r   <= 7'h00;
      acc_r   <= {(SW+7){1'b0}};
      pace_r  <= {FLMAX{1'b0}};
      hcnt_r  <= 2'd0;
      s0_r    <= {SW{1'b0}};
      s1_r    <= {SW{1'b0}};
      s2_r    <= {SW{1'b0}};
      ph_r    <= {FLMAX{1'b0}};
      pmask_r <= {MW{1'b0}};
      wv_r    <= 1'b0;
      wa_r    <= {AW{1'b0}};
      wd_r    <= {SW{1'b0}};
      wreal_r <= 1'b0;
    end
    else
    begin
      wv_r <= 1'b0;
      if (wr_go && (wsel_r == R_STAT) && hwdata[`ASC_ST_DONE])
        done_r <= 1'b0;
      else if (start_w)
        done_r <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (start_w)
          begin
            state_r   <= S_ARM;
            mode_r    <= mode_w;
            fl_r      <= fl_w;
            dig_route <= route_w;
            pmask_r   <= {MW{1'b0}};
          end
        end
        S_ARM:
        begin
          if (trig_edge)
          begin
            state_r <= S_CAP;
            pidx_r  <= {(AW+1){1'b0}};
            sub_r   <= 7'h00;
            pace_r  <= {FLMAX{1'b0}};
            hcnt_r  <= 2'd0;
            ph_r    <= ph_s2_r;
            lane_r  <= asc_next_lane(dig_route, recch, 2'd3);
          end
        end
        S_CAP:
        begin
          lane_r <= asc_next_lane(dig_route, recch, lane_r);
          case (mode_r)
            M_RT:
            begin
              acc_r <= pmax ? max_w : sum_w;
              if (sub_r == sub_lst)
              begin
                sub_r   <= 7'h00;
                wv_r    <= 1'b1;
                wa_r    <= pidx_r[AW-1:0];
                wd_r    <= pmax ? max_w[SW-1:0] : avg_w[SW-1:0];
                wreal_r <= 1'b1;
                pidx_r  <= pnext;
                if (pnext == rlen_r)
                begin
                  state_r <= S_IDLE;
                  done_r  <= 1'b1;
                end
              end
              else
                sub_r <= sub_r + 7'h01;
            end
            M_IP:
            begin
              if (pace_r == pace_lst)
              begin
                pace_r <= {FLMAX{1'b0}};
                s0_r   <= s1_r;
                s1_r   <= s2_r;
                s2_r   <= smp;
                if (hcnt_r != 2'd3)
                  hcnt_r <= hcnt_r + 2'd1;
              end
              else
                pace_r <= pace_r + {{(FLMAX-1){1'b0}}, 1'b1};
              if (hcnt_r == 2'd3)
              begin
                wv_r    <= 1'b1;
                wa_r    <= pidx_r[AW-1:0];
                wreal_r <= (pace_r == {FLMAX{1'b0}});
                pidx_r  <= pnext;
                if (pnext == rlen_r)
                begin
                  state_r <= S_IDLE;
                  done_r  <= 1'b1;
                end
              end
            end
            default:
            begin
              if (eidx < {{FLMAX{1'b0}}, rlen_r})
              begin
                wv_r    <= 1'b1;
                wa_r    <= eidx[AW-1:0];
                wd_r    <= smp;
                wreal_r <= 1'b1;
                pidx_r  <= pnext;
              end
              else
              begin
                pmask_r <= pm_nxt;
                if ((pm_nxt & pm_all) == pm_all)
                begin
                  state_r <= S_IDLE;
                  done_r  <= 1'b1;
                end
                else
                  state_r <= S_ARM;
              end
            end
          endcase
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ============================================================
  // interpolator and record memory
  asc_interp #(
    .SW   (SW)
  ) u_interp (
    .clk  (hclk),
    .s0   (s0_r),
    .s1   (s1_r),
    .s2   (s2_r),
    .frac (fr_w[7:0]),
    .sinc (sinc),
    .y    (y_ip)
  );

  asc_rec_mem #(
    .DW    (SW + 1),
    .AW    (AW)
  ) u_mem (
    .clk   (hclk),
    .we    (wv_r),
    .waddr (wa_r),
    .wdata ({wreal_r, wdat}),
    .raddr (rdaddr_r),
    .rdata (rd_mem)
  );

  // ============================================================
  // point stream out
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pt_valid <= 1'b0;
      pt_index <= {AW{1'b0}};
      pt_data  <= {SW{1'b0}};
      pt_real  <= 1'b0;
    end
    else
    begin
      pt_valid <= wv_r;
      pt_index <= wa_r;
      pt_data  <= wdat;
      pt_real  <= wreal_r;
    end
  end

endmodule // asc_acq_top

// ---- test/asc_acq_props.sv ----
// property checker for the acquisition control block
`timescale 1ns/1ps
module asc_acq_props #(
  parameter SW    = 8,
  parameter AW    = 14,
  parameter FLMAX = 4
) (
  // clock and reset
  input wire             hclk,
  input wire             hresetn,
  // bus
  input wire             hsel,
  input wire [31:0]      haddr,
  input wire [1:0]       htrans,
  input wire             hwrite,
  input wire [2:0]       hsize,
  input wire             hready,
  input wire [31:0]      hwdata,
  input wire             hreadyout,
  input wire             hresp,
  input wire [31:0]      hrdata,
  // front end
  input wire [4*SW-1:0]  adc_d,
  input wire             trig_pin,
  input wire [FLMAX-1:0] et_phase_pin,
  input wire [7:0]       dig_route,
  // point stream
  input wire             pt_valid,
  input wire [AW-1:0]    pt_index,
  input wire [SW-1:0]    pt_data,
  input wire             pt_real
);
  // ============================================================
  // bus tracking
  reg         rd_dp_r;
  reg         wr_dp_r;
  reg  [7:0]  a_dp_r;
  reg  [31:0] ctrl_r;
  reg  [AW:0] rlen_r;
  wire        ap    = hsel && hready && htrans[1];
  wire        wr_cw = wr_dp_r && (a_dp_r == 8'h00);
  wire [2:0]  lf    = (ctrl_r[18:16] > 3'd4) ? 3'd4 : ctrl_r[18:16];
  wire [AW-1:0] f_w = 1 << lf;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rd_dp_r <= 1'b0;
      wr_dp_r <= 1'b0;
      a_dp_r  <= 8'h00;
      ctrl_r  <= 32'h0000_00F0;
      rlen_r  <= 500;
    end
    else
    begin
      if (wr_cw)
        ctrl_r <= hwdata;
      if (wr_dp_r && a_dp_r == 8'h04)
        rlen_r <= hwdata[AW:0];
      rd_dp_r <= ap && !hwrite;
      wr_dp_r <= ap && hwrite;
      if (ap)
        a_dp_r <= haddr[7:0];
    end
  function lend_ok(input [7:0] r);
    integer d;
    reg [1:0] c;
    begin
      lend_ok = 1'b1;
      for (d = 0; d < 4; d = d + 1)
      begin
        c = r[2*d+:2];
        if (c != d[1:0] && r[2*c+:2] != c)
          lend_ok = 1'b0;
      end
    end
  endfunction
  // ============================================================
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  chk_rd_idle: assert property (!rd_dp_r |-> hrdata == 32'h0)
    else $error("read data outside a read");
  chk_unmapped_rd: assert property (rd_dp_r && a_dp_r >= 8'h18 |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_start_rd0: assert property (rd_dp_r && a_dp_r == 8'h00 |-> !hrdata[0])
    else $error("start bit reads one");
  chk_route_lends: assert property (lend_ok(dig_route))
    else $error("digitizer lent to an idle channel");
  chk_route_hold: assert property ($changed(dig_route) |->
    $past(wr_cw) || $past(wr_cw, 2))
    else $error("routing moved without a start");
  chk_idx_range: assert property (pt_valid |-> pt_index < rlen_r)
    else $error("point beyond record length");
  chk_idx_step: assert property (pt_valid && $past(pt_valid) |->
    pt_index == $past(pt_index) + 1'b1 || pt_index == $past(pt_index) + f_w)
    else $error("point index step wrong");
  chk_interp_real: assert property (pt_valid && !pt_real |->
    (pt_index & (f_w - 1'b1)) != 0)
    else $error("interval start tagged interpolated");
  cover property (pt_valid && !pt_real);
  cover property ($rose(trig_pin));
  cover property ($changed(dig_route));
endmodule // asc_acq_props

bind asc_acq_top asc_acq_props #(.SW(SW), .AW(AW), .FLMAX(FLMAX))
  i_asc_acq_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .adc_d(adc_d), .trig_pin(trig_pin),
  .et_phase_pin(et_phase_pin), .dig_route(dig_route),
  .pt_valid(pt_valid), .pt_index(pt_index), .pt_data(pt_data),
  .pt_real(pt_real));

// ---- test/asc_fe_model.sv ----
// front end and trigger source model
`timescale 1ns/1ps
module asc_fe_model #(
  parameter SW    = 8,
  parameter FLMAX = 4
) (
  // sample clock and input level
  input  wire             hclk,
  input  wire [SW-1:0]    level,
  // to the block
  output wire [4*SW-1:0]  adc_d,
  output reg              trig_pin,
  output reg  [FLMAX-1:0] et_phase_pin
);
  assign adc_d = {4{level}};
  initial
  begin
    trig_pin = 1'b0;
    et_phase_pin = '0;
  end
  // trigger off the clock grid, phase held round the edge
  task fire(input [FLMAX-1:0] p);
  begin
    #1.3 et_phase_pin = p;
    repeat (4) @(posedge hclk);
    #1.3 trig_pin = 1'b1;
    repeat (8) @(posedge hclk);
    #1.3 trig_pin = 1'b0;
    repeat (2) @(posedge hclk);
    #1.3 et_phase_pin = ~p;
  end
  endtask
endmodule // asc_fe_model

// ---- test/tb.sv ----
// self-checking bench for the acquisition control block
`timescale 1ns/1ps
`include "asc_map.vh"
module tb;
  // ============================================================
  // signals
  reg         hclk, hresetn, hsel, hwrite;
  reg  [31:0] haddr, hwdata;
  reg  [1:0]  htrans;
  reg  [2:0]  hsize;
  reg  [7:0]  lvl;
  wire        hready, hreadyout, hresp, pt_valid, pt_real, trig_pin;
  wire [31:0] hrdata, adc_d;
  wire [3:0]  et_phase_pin;
  wire [7:0]  dig_route, pt_data;
  wire [13:0] pt_index;
  integer     num_errors, checks_done, seed, r, k;
  reg  [22:0] exp_q[$];
  reg  [31:0] ct[0:7];
  reg  [23:0] sc[0:7];
  assign hready = hreadyout;
  asc_acq_top i_asc_acq_top (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .adc_d(adc_d), .trig_pin(trig_pin), .et_phase_pin(et_phase_pin),
    .dig_route(dig_route), .pt_valid(pt_valid), .pt_index(pt_index),
    .pt_data(pt_data), .pt_real(pt_real));
  asc_fe_model i_asc_fe_model (.hclk(hclk), .level(lvl), .adc_d(adc_d),
    .trig_pin(trig_pin), .et_phase_pin(et_phase_pin));
  // ============================================================
  // helpers
  task automatic chk(input [31:0] a, input [31:0] e);
  begin
    checks_done = checks_done + 1;
    if (a !== e)
    begin
      num_errors = num_errors + 1;
      $display("[ERR] %0t mismatch got %h exp %h", $time, a, e);
    end
  end
  endtask
  task wait_rdy;
    integer n;
  begin
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 64)
    begin
      n = n + 1;
      @(posedge hclk);
    end
    chk(n < 64, 1);
  end
  endtask
  task ahb(input w, input [7:0] a, input [31:0] wd, output [31:0] rd);
  begin
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg [31:0] v;
  begin
    ahb(1'b1, a, d, v);
  end
  endtask
  task rd_chk(input [7:0] a, input [31:0] e);
    reg [31:0] v;
  begin
    ahb(1'b0, a, 32'h0, v);
    chk(v, e);
  end
  endtask
  task wait_q;
    integer n;
  begin
    n = 0;
    while (exp_q.size() != 0 && n < 5000)
    begin
      n = n + 1;
      @(posedge hclk);
    end
    chk(exp_q.size(), 0);
    repeat (4) @(posedge hclk);
  end
  endtask
  function [7:0] route_of(input [3:0] on);
    integer d, j;
    reg [1:0] c;
  begin
    for (d = 0; d < 4; d = d + 1)
    begin
      c = d[1:0];
      for (j = 3; j >= 1; j = j - 1)
        if (!on[d] && on[d[1:0] ^ j[1:0]])
          c = d[1:0] ^ j[1:0];
      route_of[2*d+:2] = c;
    end
  end
  endfunction
  function [1:0] mode_of(input [31:0] c, input [23:0] s);
    integer n, mn;
    reg fast;
  begin
    n = c[4] + c[5] + c[6] + c[7];
    mn = (n == 1) ? 250 : (n == 2) ? 1000 : 2000;
    fast = c[3] ? (s < 10000) : (s < mn);
    mode_of = !fast ? 2'd0 : (c[1] && !c[3]) ? 2'd1 : 2'd2;
  end
  endfunction
  // ============================================================
  // one capture with expectations
  task run(input [31:0] c, input [23:0] s);
    integer f, p, i, len;
    reg [1:0]  m;
    reg [7:0]  lv;
    reg [31:0] v;
  begin
    r = $random(seed);
    len = 8 + r[3:0];
    lv = r[15:8];
    lvl <= lv;
    m = mode_of(c, s);
    f = 1 << ((c[18:16] > 3'd4) ? 4 : c[18:16]);
    wr(`ASC_OFF_RLEN, len);
    wr(`ASC_OFF_SCALE, {8'h00, s});
    wr(`ASC_OFF_CTRL, c | 32'h0000_0001);
    ahb(1'b0, `ASC_OFF_STATUS, 32'h0, v);
    chk(v & 32'h0000_000F, {28'h0, m, 2'b01});
    chk({24'h0, dig_route}, {24'h0, route_of(c[7:4])});
    for (p = 0; p < ((m == 2'd1) ? f : 1); p = p + 1)
    begin
      for (i = 0; i < len; i = i + 1)
        if (m != 2'd1 || i % f == p)
          exp_q.push_back({i[13:0], m != 2'd2 || i % f == 0, lv});
      i_asc_fe_model.fire(p[3:0]);
      wait_q;
    end
    ahb(1'b0, `ASC_OFF_STATUS, 32'h0, v);
    chk(v & 32'h0000_0003, 32'h0000_0002);
    wr(`ASC_OFF_STATUS, 32'h0000_0002);
    rd_chk(`ASC_OFF_STATUS & 8'hFF, v & 32'hFFFF_FFFD);
    wr(`ASC_OFF_RDADDR, 32'h0);
    repeat (2) @(posedge hclk);
    rd_chk(`ASC_OFF_RDDATA, {23'h0, 1'b1, lv});
    $display("run ctrl %h mode %0d done", c, m);
  end
  endtask
  task results;
  begin
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  // ============================================================
  // point monitor
  always @(posedge hclk)
    if (pt_valid === 1'b1)
      chk({9'h0, pt_index, pt_real, pt_data},
        (exp_q.size() != 0) ? {9'h0, exp_q.pop_front()} : 32'hFFFF_FFFF);
  // ============================================================
  // clock, watchdog, main sequence
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial
  begin
    repeat (50000) @(posedge hclk);
    num_errors = num_errors + 1;
    $display("[ERR] %0t watchdog expired", $time);
    results;
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b1;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    lvl = 8'h00;
    num_errors = 0;
    checks_done = 0;
    seed = 90;
    ct = '{32'h0000_1010, 32'h0000_24F0, 32'h0001_0030, 32'h0002_0074,
      32'h0002_0012, 32'h0001_00F2, 32'h0001_001A, 32'h0001_0010};
    sc = '{24'h00_01F4, 24'h00_0BB8, 24'h00_01F4, 24'h00_05DC,
      24'h00_00C8, 24'h00_05DC, 24'h00_1388, 24'h00_00C8};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(`ASC_OFF_CTRL, 32'h0000_00F0);
    rd_chk(`ASC_OFF_RLEN, 32'h0000_01F4);
    rd_chk(`ASC_OFF_SCALE, 32'h0000_03E8);
    wr(8'h18, 32'hFFFF_FFFF);
    rd_chk(8'h18, 32'h0000_0000);
    $display("register reset test done");
    for (k = 0; k < 8; k = k + 1)
      run(ct[k], sc[k]);
    results;
  end
endmodule // tb
